// >>> hdl/adcm_params.svh
// constants for the two-wire converter setup master
// What this block does
// - one bit per clock cycle; an acknowledged transfer takes at least eighteen cycles, a refused address stops after nine
// - data stable while clock high; changes then are bus conditions
// - start is data falling, stop is data rising, both while clock high
// - repeated start may replace stop, bus stays active, speed mode kept
// - acknowledge: receiver drives data low across the ninth clock high
// - not-acknowledge: receiver releases data high across the ninth clock high
// - after a missing acknowledge the master issues stop and sets the nack status bit, with no retry
// - address byte last bit: 0 write, 1 read
// - device starts in fast mode; master code 00001xxx selects high speed
// - after master code master issues repeated start and slave address
// - one or two bytes, setup byte first then configuration; each good byte acknowledged
// - master closes a write cycle with stop
`ifndef ADCM_PARAMS_SVH
`define ADCM_PARAMS_SVH
`define ADCM_CLK_MHZ 250
`define ADCM_FS_KHZ 400
`define ADCM_HS_KHZ 1700
// quarter bit periods, rounded up so the bus is never overclocked
`define ADCM_FS_QTR ((`ADCM_CLK_MHZ * 1000 + 4 * `ADCM_FS_KHZ - 1) / (4 * `ADCM_FS_KHZ))
`define ADCM_HS_QTR ((`ADCM_CLK_MHZ * 1000 + 4 * `ADCM_HS_KHZ - 1) / (4 * `ADCM_HS_KHZ))
// slave address value is arbitrary, set it to the fitted part
`define ADCM_SLAVE_ADDR 7'h2a
`define ADCM_MCODE 8'h09
`define ADCM_SETUP_MSB 7
`define ADCM_REF_LSB 4
`define ADCM_CLKSEL_BIT 3
`define ADCM_BIPOLAR_BIT 2
`define ADCM_CFGRST_BIT 1
`define ADCM_REG_CTRL 4'h0
`define ADCM_REG_DATA 4'h4
`define ADCM_REG_STAT 4'h8
`define ADCM_CTRL_GO 0
`define ADCM_CTRL_TWO 1
`define ADCM_CTRL_HS 2
`define ADCM_AXI_OKAY 2'b00
`define ADCM_AXI_SLVERR 2'b10
`endif

// >>> hdl/adcm_pkg.sv
// types for the two-wire converter setup master
package adcm_pkg;
    typedef enum logic [9:0] {
        ADCM_IDLE = 10'b0000000001,
        ADCM_START = 10'b0000000010,
        ADCM_BIT = 10'b0000000100,
        ADCM_ACK = 10'b0000001000,
        ADCM_NEXT = 10'b0000010000,
        ADCM_RSTART = 10'b0000100000,
        ADCM_STOP = 10'b0001000000,
        ADCM_STOP2 = 10'b0010000000,
        ADCM_STOP3 = 10'b0100000000,
        ADCM_DONE = 10'b1000000000
    } adcm_state_e;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } adcm_pins_s;
    typedef struct packed {
        logic [2:0] sync;
        logic level;
    } adcm_sync_s;
endpackage : adcm_pkg

// >>> hdl/adcm_sync.sv
// three-stage synchroniser for a pin level
`timescale 1ns/1ps
`include "adcm_params.svh"
module adcm_sync (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    output logic level_o
);
    import adcm_pkg::*;
    adcm_sync_s st_reg;
    adcm_sync_s st_next;
    always_comb begin
        st_next = st_reg;
        st_next.sync = {st_reg.sync[1:0], pin_i};
        // change counts once stages two and three agree
        if (st_reg.sync[1] == st_reg.sync[2]) begin
            st_next.level = st_reg.sync[2];
        end
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '{sync: 3'h7, level: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end
    assign level_o = st_reg.level;
endmodule : adcm_sync

// >>> hdl/adcm_master.sv
// two-wire master that writes setup and configuration bytes, driven over axi4-lite
`timescale 1ns/1ps
`include "adcm_params.svh"
module adcm_master (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic scl_i,
    input wire logic sda_i,
    output adcm_pkg::adcm_pins_s pins_o
);
    import adcm_pkg::*;

    localparam logic [15:0] FS_QTR = 16'(`ADCM_FS_QTR);
    localparam logic [15:0] HS_QTR = 16'(`ADCM_HS_QTR);

    typedef struct packed {
        adcm_state_e st;
        logic [1:0] phase;
        logic [15:0] tick;
        logic [3:0] bitn;
        logic [8:0] shift;
        logic [1:0] idx;
        logic [1:0] nbytes;
        logic hs;
        logic busy;
        logic nack;
        logic hs_active;
        logic [7:0] setup_b;
        logic [7:0] config_b;
        logic two;
        logic hs_req;
        logic aw_got;
        logic w_got;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        adcm_pins_s pins;
    } adcm_core_s;

    adcm_core_s r_reg;
    adcm_core_s r_next;
    logic scl_s;
    logic sda_s;

    adcm_sync u_scl_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pin_i(scl_i),
        .level_o(scl_s)
    );
    adcm_sync u_sda_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pin_i(sda_i),
        .level_o(sda_s)
    );

    // ------------------------------------------------------------
    // byte for the current slot of the frame
    // ------------------------------------------------------------
    function automatic logic [7:0] slot_byte(input adcm_core_s r, input logic [1:0] i);
        logic [7:0] b;
        b = 8'h00;
        if (r.hs && i == 2'd0) begin
            b = `ADCM_MCODE;
        end else if (i == 2'd0 || (r.hs && i == 2'd1)) begin
            b = {`ADCM_SLAVE_ADDR, 1'b0};
        end else if (i == (r.hs ? 2'd2 : 2'd1)) begin
            b = r.setup_b;
        end else begin
            b = r.config_b;
        end
        return b;
    endfunction : slot_byte

    always_comb begin
        logic q;
        logic sda_rel;
        q = 1'b0;
        sda_rel = 1'b0;
        r_next = r_reg;

        // ------------------------------------------------------------
        // axi4-lite slave
        // ------------------------------------------------------------
        r_next.awready = 1'b0;
        r_next.wready = 1'b0;
        r_next.arready = 1'b0;
        if (s_awvalid && !r_reg.aw_got && !r_reg.awready && !r_reg.bvalid) begin
            r_next.awready = 1'b1;
            r_next.awaddr = s_awaddr;
            r_next.aw_got = 1'b1;
        end
        if (s_wvalid && !r_reg.w_got && !r_reg.wready && !r_reg.bvalid) begin
            r_next.wready = 1'b1;
            r_next.wdata = s_wdata;
            r_next.wstrb = s_wstrb;
            r_next.w_got = 1'b1;
        end
        if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = `ADCM_AXI_OKAY;
            if (r_reg.awaddr == `ADCM_REG_CTRL) begin
                if (r_reg.wstrb[0] && r_reg.wdata[`ADCM_CTRL_GO] && !r_reg.busy) begin
                    r_next.two = r_reg.wdata[`ADCM_CTRL_TWO];
                    r_next.hs_req = r_reg.wdata[`ADCM_CTRL_HS];
                    r_next.busy = 1'b1;
                end
            end else if (r_reg.awaddr == `ADCM_REG_DATA) begin
                if (r_reg.wstrb[0]) begin
                    // bit 7 forced: setup byte, bit 0 don't care
                    r_next.setup_b = {1'b1, r_reg.wdata[6:1], 1'b0};
                end
                if (r_reg.wstrb[1]) begin
                    r_next.config_b = {1'b0, r_reg.wdata[14:8]};
                end
            end else if (r_reg.awaddr != `ADCM_REG_STAT) begin
                r_next.bresp = `ADCM_AXI_SLVERR;
            end
        end else if (r_reg.bvalid && s_bready) begin
            r_next.bvalid = 1'b0;
        end
        if (s_arvalid && !r_reg.rvalid && !r_reg.arready) begin
            r_next.arready = 1'b1;
            r_next.rvalid = 1'b1;
            r_next.rresp = `ADCM_AXI_OKAY;
            if (s_araddr == `ADCM_REG_CTRL) begin
                r_next.rdata = {29'h0, r_reg.hs_req, r_reg.two, r_reg.busy};
            end else if (s_araddr == `ADCM_REG_DATA) begin
                r_next.rdata = {16'h0, r_reg.config_b, r_reg.setup_b};
            end else if (s_araddr == `ADCM_REG_STAT) begin
                r_next.rdata = {29'h0, r_reg.hs_active, r_reg.nack, r_reg.busy};
            end else begin
                r_next.rdata = 32'h0;
                r_next.rresp = `ADCM_AXI_SLVERR;
            end
        end else if (r_reg.rvalid && s_rready) begin
            r_next.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // quarter-bit enable from the divider; high speed shortens it
        // ------------------------------------------------------------
        r_next.tick = r_reg.tick + 16'd1;
        if (r_reg.tick >= (r_reg.hs_active ? HS_QTR : FS_QTR) - 16'd1) begin
            r_next.tick = 16'd0;
            q = 1'b1;
        end

        // ------------------------------------------------------------
        // bus sequencer: phase 0 scl low, 1 rise, 2 high sample, 3 fall
        // ------------------------------------------------------------
        if (q) begin
            r_next.phase = r_reg.phase + 2'd1;
            case (r_reg.st)
                ADCM_IDLE: begin
                    r_next.phase = 2'd0;
                    if (r_reg.busy && scl_s && sda_s) begin
                        r_next.hs = r_reg.hs_req;
                        r_next.idx = 2'd0;
                        r_next.nack = 1'b0;
                        r_next.nbytes = (r_reg.hs_req ? 2'd3 : 2'd2) + {1'b0, r_reg.two};
                        r_next.st = ADCM_START;
                    end
                end
                ADCM_START: begin
                    // data falls while clock high, then clock falls
                    if (r_reg.phase == 2'd0) begin
                        r_next.pins.sda_o = 1'b0;
                    end else if (r_reg.phase == 2'd1) begin
                        r_next.pins.scl_o = 1'b0;
                        r_next.shift = {slot_byte(r_reg, r_reg.idx), 1'b1};
                        r_next.bitn = 4'd0;
                        r_next.phase = 2'd0;
                        r_next.st = ADCM_BIT;
                    end
                end
                ADCM_BIT, ADCM_ACK: begin
                    // data only changes while clock low
                    if (r_reg.phase == 2'd0) begin
                        r_next.pins.sda_o = r_reg.shift[8];
                    end else if (r_reg.phase == 2'd1) begin
                        r_next.pins.scl_o = 1'b1;
                    end else if (r_reg.phase == 2'd2) begin
                        // wait here while the device stretches the clock
                        if (!scl_s) begin
                            r_next.phase = 2'd2;
                        end else if (r_reg.st == ADCM_ACK) begin
                            sda_rel = sda_s;
                            if (r_reg.hs && r_reg.idx == 2'd0) begin
                                // master code: no one may acknowledge
                                r_next.hs_active = 1'b1;
                                if (!sda_rel) begin
                                    r_next.nack = 1'b1;
                                end
                            end else if (sda_rel) begin
                                r_next.nack = 1'b1;
                            end
                        end
                    end else begin
                        r_next.pins.scl_o = 1'b0;
                        r_next.shift = {r_reg.shift[7:0], 1'b1};
                        r_next.bitn = r_reg.bitn + 4'd1;
                        if (r_reg.st == ADCM_ACK) begin
                            r_next.st = ADCM_NEXT;
                        end else if (r_reg.bitn == 4'd7) begin
                            // ninth clock: release data for the acknowledge
                            r_next.st = ADCM_ACK;
                        end
                    end
                end
                ADCM_NEXT: begin
                    r_next.phase = 2'd0;
                    r_next.idx = r_reg.idx + 2'd1;
                    if (r_reg.nack) begin
                        r_next.st = ADCM_STOP;
                    end else if (r_reg.idx + 2'd1 == r_reg.nbytes) begin
                        r_next.st = ADCM_STOP;
                    end else if (r_reg.hs && r_reg.idx == 2'd0) begin
                        r_next.st = ADCM_RSTART;
                    end else begin
                        r_next.shift = {slot_byte(r_reg, r_reg.idx + 2'd1), 1'b1};
                        r_next.bitn = 4'd0;
                        r_next.st = ADCM_BIT;
                    end
                end
                ADCM_RSTART: begin
                    if (r_reg.phase == 2'd0) begin
                        r_next.pins.sda_o = 1'b1;
                    end else if (r_reg.phase == 2'd1) begin
                        r_next.pins.scl_o = 1'b1;
                    end else if (r_reg.phase == 2'd2 && !scl_s) begin
                        r_next.phase = 2'd2;
                    end else if (r_reg.phase == 2'd3) begin
                        r_next.phase = 2'd0;
                        r_next.st = ADCM_START;
                    end
                end
                ADCM_STOP: begin
                    r_next.pins.sda_o = 1'b0;
                    r_next.phase = 2'd0;
                    r_next.st = ADCM_STOP2;
                end
                ADCM_STOP2: begin
                    r_next.pins.scl_o = 1'b1;
                    r_next.phase = 2'd0;
                    if (scl_s) begin
                        r_next.st = ADCM_STOP3;
                    end
                end
                ADCM_STOP3: begin
                    // data rises while clock high; stop drops high speed
                    r_next.pins.sda_o = 1'b1;
                    r_next.hs_active = 1'b0;
                    r_next.phase = 2'd0;
                    r_next.st = ADCM_DONE;
                end
                default: begin
                    r_next.busy = 1'b0;
                    r_next.phase = 2'd0;
                    r_next.st = ADCM_IDLE;
                end
            endcase
        end
        // open drain: enable only while pulling low
        r_next.pins.scl_oe = !r_next.pins.scl_o;
        // the acknowledge slot releases data a quarter after the clock falls, never with it
        r_next.pins.sda_oe = !r_next.pins.sda_o;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg <= '0;
            r_reg.st <= ADCM_IDLE;
            // device defaults: reference 000, internal clock, unipolar, no config reset
            r_reg.setup_b <= 8'h82;
            r_reg.config_b <= 8'h01;
            r_reg.pins <= '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_awready = r_reg.awready;
    assign s_wready = r_reg.wready;
    assign s_bvalid = r_reg.bvalid;
    assign s_bresp = r_reg.bresp;
    assign s_arready = r_reg.arready;
    assign s_rvalid = r_reg.rvalid;
    assign s_rdata = r_reg.rdata;
    assign s_rresp = r_reg.rresp;
    assign pins_o = r_reg.pins;
endmodule : adcm_master

// >>> test/adcm_master_asserts.sv
// port-level assertions for the two-wire setup master
`timescale 1ns/1ps
module adcm_master_asserts (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic s_awready,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arvalid,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    input wire adcm_pkg::adcm_pins_s pins_o
);
    import adcm_pkg::*;
    logic [15:0] hi_cnt_reg;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // --------------------------------
    // helper: length of the clock-high phase
    // --------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_cnt_reg <= 16'h0;
        end else if (pins_o.scl_oe) begin
            hi_cnt_reg <= 16'h0;
        end else if (hi_cnt_reg != 16'hffff) begin
            hi_cnt_reg <= hi_cnt_reg + 16'h1;
        end
    end
    // --------------------------------
    // assertions
    // --------------------------------
    AST_SDA_PULL_LOW: assert property (pins_o.sda_oe |-> !pins_o.sda_o)
        else $error("data driven high while enabled");
    AST_SCL_PULL_LOW: assert property (pins_o.scl_oe |-> !pins_o.scl_o)
        else $error("clock driven high while enabled");
    AST_NO_JOINT_EDGE: assert property ($changed(pins_o.sda_oe) |-> !$changed(pins_o.scl_oe))
        else $error("data and clock moved together");
    AST_START_CLOCKS: assert property ($rose(pins_o.sda_oe) && !pins_o.scl_oe |-> ##[1:700] pins_o.scl_oe)
        else $error("start not followed by clocking");
    AST_STOP_IDLE: assert property ($fell(pins_o.sda_oe) && !pins_o.scl_oe |=> (!pins_o.sda_oe && !pins_o.scl_oe) [*8])
        else $error("bus not idle after stop");
    AST_HIGH_PHASE: assert property ($rose(pins_o.scl_oe) |-> hi_cnt_reg >= 16'h46)
        else $error("clock high phase too short");
    AST_BVALID_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
    AST_AWREADY_PULSE: assert property (s_awready |=> !s_awready)
        else $error("awready longer than one cycle");
    AST_WRITE_ANSWER: assert property (s_awready && s_wready |-> ##[1:3] s_bvalid)
        else $error("write response late");
    AST_READ_CAUSE: assert property ($rose(s_rvalid) |-> $past(s_arvalid))
        else $error("read data without request");
    COV_SLVERR: cover property (s_bvalid && s_bready && s_bresp == 2'b10);
    COV_START: cover property ($rose(pins_o.sda_oe) && !pins_o.scl_oe);
    COV_READ: cover property (s_rvalid && s_rready);
endmodule : adcm_master_asserts

bind adcm_master adcm_master_asserts adcm_master_asserts_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .s_awready(s_awready), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .pins_o(pins_o));

// >>> test/adcm_dev_model.sv
// behavioural converter slave on the two-wire bus holding setup and configuration
`timescale 1ns/1ps
`include "adcm_params.svh"
module adcm_dev_model #(
    // arbitrary address, chosen to match the master's build constant
    parameter logic [6:0] DEV_ADDR = `ADCM_SLAVE_ADDR
) (
    input wire logic nrst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic refuse_i,
    input wire logic stretch_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic [7:0] setup_o,
    output logic [7:0] config_o,
    output logic hs_o,
    output logic [7:0] edges_o,
    output logic [7:0] hs_cnt_o
);
    logic [7:0] sh;
    logic [3:0] bits;
    logic addr_ph, sel, scl_q, sda_q;
    initial scl_oe_o = 1'b0;
    // slow answer: hold the clock low after every falling edge
    always @(negedge scl_i) begin
        if (stretch_i) begin
            scl_oe_o = 1'b1;
            #2000;
            scl_oe_o = 1'b0;
        end
    end
    always @(scl_i or sda_i or nrst_i) begin
        if (!nrst_i) begin
            sda_oe_o = 1'b0;
            setup_o = 8'h0;
            config_o = 8'h01;
            hs_o = 1'b0;
            edges_o = 8'h0;
            hs_cnt_o = 8'h0;
            bits = 4'h0;
            addr_ph = 1'b0;
            sel = 1'b0;
            scl_q = 1'b1;
            sda_q = 1'b1;
        end else begin
            if (scl_i && scl_q && sda_q && !sda_i) begin
                bits = 4'h0;
                addr_ph = 1'b1;
                edges_o = 8'h0;
            end else if (scl_i && scl_q && !sda_q && sda_i) begin
                hs_o = 1'b0;
                addr_ph = 1'b0;
                sel = 1'b0;
            end else if (scl_i && !scl_q) begin
                sh = {sh[6:0], sda_i};
                bits = bits + 4'h1;
                edges_o = edges_o + 8'h1;
            end else if (!scl_i && scl_q && bits == 4'h8) begin
                if (addr_ph && sh[7:3] == 5'h01) begin
                    hs_o = 1'b1;
                    hs_cnt_o = hs_cnt_o + 8'h1;
                end else if (addr_ph) begin
                    sel = (sh == {DEV_ADDR, 1'b0}) && !refuse_i;
                    sda_oe_o = sel;
                end else if (sel && sh[7]) begin
                    setup_o = {sh[7:1], 1'b0};
                    if (!sh[1]) config_o = 8'h01;
                    sda_oe_o = 1'b1;
                end else if (sel) begin
                    config_o = sh;
                    sda_oe_o = 1'b1;
                end
            end else if (!scl_i && scl_q && bits == 4'h9) begin
                sda_oe_o = 1'b0;
                bits = 4'h0;
                addr_ph = 1'b0;
            end
            scl_q = scl_i;
            sda_q = sda_i;
        end
    end
endmodule : adcm_dev_model

// >>> test/tb.sv
// self-checking bench for the two-wire setup master
`timescale 1ns/1ps
`include "adcm_params.svh"
module tb;
    import adcm_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
    logic [31:0] s_wdata = 32'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    adcm_pins_s pins;
    logic scl_w, sda_w, dev_scl_oe, dev_sda_oe, hs, refuse = 1'b0, stretch = 1'b0;
    logic [7:0] setup_q, config_q, edges, hs_cnt;
    int bad_count = 0;
    int checks = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    // open-drain wires with pull-ups
    assign scl_w = !(pins.scl_oe | dev_scl_oe);
    assign sda_w = !(pins.sda_oe | dev_sda_oe);
    adcm_master adcm_master_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .scl_i(scl_w), .sda_i(sda_w), .pins_o(pins));
    adcm_dev_model adcm_dev_model_inst (.nrst_i(nrst_i), .scl_i(scl_w), .sda_i(sda_w), .refuse_i(refuse),
        .stretch_i(stretch), .scl_oe_o(dev_scl_oe), .sda_oe_o(dev_sda_oe), .setup_o(setup_q),
        .config_o(config_q), .hs_o(hs), .edges_o(edges), .hs_cnt_o(hs_cnt));
    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        if (bad_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic timeout;
        check(32'h0, 32'h1);
        results();
    endtask : timeout
    // --------------------------------
    // axi4-lite master
    // --------------------------------
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge ref_clk_i);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            n++;
        end while (s_bvalid !== 1'b1 && n < 100);
        if (n >= 100) timeout();
        s_bready <= 1'b0;
        check(32'(s_bresp), 32'(er));
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            if (s_arready) s_arvalid <= 1'b0;
            n++;
        end while (s_rvalid !== 1'b1 && n < 100);
        if (n >= 100) timeout();
        s_rready <= 1'b0;
        d = s_rdata;
        check(32'(s_rresp), 32'(er));
    endtask : axi_rd
    // start a frame and poll until the master is idle again
    task automatic go(input logic [31:0] ctrl, output logic [31:0] st);
        int n;
        axi_wr(`ADCM_REG_CTRL, ctrl, `ADCM_AXI_OKAY);
        n = 0;
        do begin
            axi_rd(`ADCM_REG_STAT, `ADCM_AXI_OKAY, st);
            n++;
        end while (st[0] !== 1'b0 && n < 8000);
        if (n >= 8000) timeout();
    endtask : go
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs;
        logic [31:0] d;
        axi_rd(`ADCM_REG_DATA, `ADCM_AXI_OKAY, d);
        check(d, 32'h0000_0182);
        axi_rd(`ADCM_REG_CTRL, `ADCM_AXI_OKAY, d);
        check(d, 32'h0);
        axi_wr(4'hc, 32'h1, `ADCM_AXI_SLVERR);
        axi_rd(4'hc, `ADCM_AXI_SLVERR, d);
        check(d, 32'h0);
        check(32'(edges), 32'h0);
    endtask : t_regs
    task automatic t_two;
        logic [31:0] st;
        axi_wr(`ADCM_REG_DATA, 32'h0000_35fd, `ADCM_AXI_OKAY);
        go(32'h3, st);
        check(32'(setup_q), 32'hfc);
        check(32'(config_q), 32'h35);
        // rising clocks: data and acknowledge bits plus the one that carries the stop
        check(32'(edges), 32'h1c);
        check(32'(setup_q[2] & ~config_q[0]), 32'h0);
        check(32'(st[1]), 32'h0);
        axi_rd(`ADCM_REG_DATA, `ADCM_AXI_OKAY, st);
        check(st, 32'h0000_35fc);
    endtask : t_two
    task automatic t_stretch;
        logic [31:0] st;
        @(posedge ref_clk_i);
        stretch <= 1'b1;
        axi_wr(`ADCM_REG_DATA, 32'h0000_0083, `ADCM_AXI_OKAY);
        go(32'h1, st);
        check(32'(setup_q), 32'h82);
        check(32'(config_q), 32'h35);
        check(32'(edges), 32'h13);
        @(posedge ref_clk_i);
        stretch <= 1'b0;
    endtask : t_stretch
    task automatic t_nack;
        logic [31:0] st;
        @(posedge ref_clk_i);
        refuse <= 1'b1;
        axi_wr(`ADCM_REG_DATA, 32'h0000_0080, `ADCM_AXI_OKAY);
        go(32'h1, st);
        check(32'(st[1]), 32'h1);
        check(32'(setup_q), 32'h82);
        @(posedge ref_clk_i);
        refuse <= 1'b0;
    endtask : t_nack
    task automatic t_hs;
        logic [31:0] st;
        go(32'h5, st);
        check(32'(hs_cnt), 32'h1);
        check(32'(edges), 32'h13);
        check(32'(setup_q), 32'h80);
        check(32'(config_q), 32'h01);
        check(32'(hs), 32'h0);
        check(32'(st[2]), 32'h0);
    endtask : t_hs
    initial begin
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_regs();
        t_two();
        t_stretch();
        t_nack();
        t_hs();
        results();
    end
endmodule : tb
